/* File: rtl/dac_ctl_pkg.sv */
package dac_ctl_pkg;
   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int NUM_CH = 8;
   localparam int CH_W = 3;
   localparam int WORD_W = 16;
   localparam int CODE_W = 12;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;
   // Resolution variant: 12, 10 or 8 bits used
   localparam int RES_BITS = 12;
   localparam logic [CODE_W-1:0] CODE_MASK =
      12'hfff << (CODE_W - RES_BITS);

   // ----------------------------------------
   // Serial word fields
   // ----------------------------------------
   localparam int TYPE_BIT = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 12;
   localparam int CMD_HI = 14;
   localparam int CMD_LO = 13;
   localparam int RST_ALL_BIT = 12;
   localparam int VDD_LO = 0;
   localparam int BUF_LO = 2;
   localparam int GAIN_LO = 4;
   localparam int LOAD_LO = 0;
   localparam int PD_LO = 0;

   typedef enum logic [1:0] {
      CMD_REFGAIN = 2'b00,
      CMD_LOAD = 2'b01,
      CMD_PDOWN = 2'b10,
      CMD_RESET = 2'b11
   } cmd_t;

   typedef enum logic [1:0] {
      LOAD_CONT = 2'b00,
      LOAD_LATCH = 2'b01,
      LOAD_SINGLE = 2'b10,
      LOAD_RSVD = 2'b11
   } load_mode_t;

   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_SHIFT = 2'b01,
      LINK_FULL = 2'b10
   } link_st_t;

   typedef struct packed {
      load_mode_t load_mode;
      logic [1:0] vdd;
      logic [1:0] gain;
      logic [1:0] bufd;
      logic [NUM_CH-1:0] pd;
   } ctl_t;

   localparam ctl_t CTL_DEFAULT = '{load_mode: LOAD_LATCH, vdd: 2'h0,
      gain: 2'h0, bufd: 2'h0, pd: 8'h00};

   // Group references actually applied to the analog side
   typedef struct packed {
      logic [1:0] vdd;
      logic [1:0] gain;
      logic [1:0] bufd;
   } ref_cfg_t;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int EXIT_5V_NS = 2500;
   localparam int EXIT_3V_NS = 5000;
   localparam int EXIT_W = 9;
   localparam logic [EXIT_W-1:0] EXIT_5V_CYC =
      EXIT_W'((EXIT_5V_NS * CLK_MHZ + 999) / 1000);
   localparam logic [EXIT_W-1:0] EXIT_3V_CYC =
      EXIT_W'((EXIT_3V_NS * CLK_MHZ + 999) / 1000);

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_LAST = 8'h08;
   localparam logic [ADDR_W-1:0] REG_ABORTS = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_SETTINGS = 8'h10;
   localparam logic [2:0] CODE_PAGE = 3'h1;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_LOWV_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage : dac_ctl_pkg

/* File: rtl/octal_dac_ctl.sv */
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Reset clears all input and output codes until a full word arrives.
// - Defaults: channels on, unbuffered, unity gain, latched load mode.
// - Power-down keeps registers and still accepts new data.
// - A powered-down channel output is flagged high impedance.
// - Leaving power-down shows the output after a 2.5 or 5 us wake.
// - A 16-bit shift register gathers one word per frame.
// - Frame select is active low; bits taken only while low.
// - Data sampled on falling serial clock edges, sixteen of them.
// - Frame end after sixteen edges stores data or runs the command.
// - A frame ending early is dropped and counted; codes and settings stay.
// - Most significant bit first; bit 15 picks data or command.
// - Bits 14 to 12 address channel one to eight in binary.
// - Data below the address; narrower variants ignore low bits.
// - Codes are straight unsigned binary.
// - Bits 14 and 13 pick ref/gain, load, power-down or reset.
// - Bits 2 and 3 set reference buffering for each group.
// - Bits 4 and 5 set doubled gain for each group.
// - Bits 0 and 1 pick supply as reference for each group.
// - Supply reference forces that group unbuffered at unity gain.
// - Load mode: 00 transparent, 01 latched, 10 one update, 11 none.
// - Power-down bits 7 to 0 map to channels eight down to one.
// - Reset word clears codes; with bit 12 set also the settings.
// - Load pin low or transparent mode copies input to output.
module octal_dac_ctl
   import dac_ctl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sync_n,
   input wire logic sclk,
   input wire logic sdin,
   input wire logic load_output_n,
   output logic [NUM_CH-1:0][CODE_W-1:0] dac_code,
   output ref_cfg_t ref_cfg,
   output logic [NUM_CH-1:0] chan_hiz,
   output logic [NUM_CH-1:0] chan_live
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] pin_q1_r, pin_q2_r;
   logic sclk_q3_r, sync_q3_r;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pin_q1_r <= 4'hf;
         pin_q2_r <= 4'hf;
         sclk_q3_r <= 1'b1;
         sync_q3_r <= 1'b1;
      end else begin
         pin_q1_r <= {load_output_n, sdin, sclk, sync_n};
         pin_q2_r <= pin_q1_r;
         sclk_q3_r <= pin_q2_r[1];
         sync_q3_r <= pin_q2_r[0];
      end
   end

   wire sync_low = !pin_q2_r[0];
   wire sync_rise = pin_q2_r[0] && !sync_q3_r;
   wire sclk_fall = sclk_q3_r && !pin_q2_r[1];
   wire sdin_s = pin_q2_r[2];
   wire load_pin_low = !pin_q2_r[3];

   // ----------------------------------------
   // Serial frame
   // ----------------------------------------
   link_st_t link_st_r;
   logic [WORD_W-1:0] shift_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic [1:0] ctrl_r;
   logic word_done, frame_abort;

   wire take_bit = sync_low && sclk_fall;
   assign word_done = (link_st_r == LINK_FULL) && sync_rise;
   assign frame_abort = (link_st_r == LINK_SHIFT) && sync_rise;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         link_st_r <= LINK_IDLE;
         bit_cnt_r <= '0;
         shift_r <= '0;
      end else begin
         unique case (link_st_r)
            LINK_IDLE: begin
               bit_cnt_r <= '0;
               if (sync_low && ctrl_r[CTRL_EN_BIT]) begin
                  link_st_r <= LINK_SHIFT;
               end
            end
            LINK_SHIFT: begin
               if (sync_rise) begin
                  link_st_r <= LINK_IDLE;
               end else if (take_bit) begin
                  shift_r <= {shift_r[WORD_W-2:0], sdin_s};
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == WORD_BITS - 5'h01) begin
                     link_st_r <= LINK_FULL;
                  end
               end
            end
            // Edges past the sixteenth are ignored
            LINK_FULL: begin
               if (sync_rise) begin
                  link_st_r <= LINK_IDLE;
               end
            end
            default: link_st_r <= LINK_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Word decode, only used at frame end
   // ----------------------------------------
   wire is_cmd = shift_r[TYPE_BIT];
   wire [CH_W-1:0] wr_ch = shift_r[ADDR_HI:ADDR_LO];
   // Ignored low bits forced to zero in case the host sends ones
   wire [CODE_W-1:0] wr_code = shift_r[CODE_W-1:0] & CODE_MASK;
   wire cmd_t cmd = cmd_t'(shift_r[CMD_HI:CMD_LO]);
   wire load_mode_t new_load = load_mode_t'(shift_r[LOAD_LO+1:LOAD_LO]);
   wire data_wr = word_done && !is_cmd;
   wire cmd_go = word_done && is_cmd;
   wire do_clear = cmd_go && (cmd == CMD_RESET);
   wire do_single = cmd_go && (cmd == CMD_LOAD) && (new_load == LOAD_SINGLE);

   // ----------------------------------------
   // Control settings
   // ----------------------------------------
   ctl_t ctl_r;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ctl_r <= CTL_DEFAULT;
      end else if (cmd_go) begin
         unique case (cmd)
            CMD_REFGAIN: begin
               ctl_r.vdd <= shift_r[VDD_LO+1:VDD_LO];
               ctl_r.bufd <= shift_r[BUF_LO+1:BUF_LO];
               ctl_r.gain <= shift_r[GAIN_LO+1:GAIN_LO];
            end
            CMD_LOAD: begin
               // Single update and reserved leave the stored mode alone
               if (new_load == LOAD_CONT || new_load == LOAD_LATCH) begin
                  ctl_r.load_mode <= new_load;
               end
            end
            CMD_PDOWN: ctl_r.pd <= shift_r[PD_LO+NUM_CH-1:PD_LO];
            CMD_RESET: begin
               if (shift_r[RST_ALL_BIT]) begin
                  ctl_r <= CTL_DEFAULT;
               end
            end
         endcase
      end
   end

   assign ref_cfg.vdd = ctl_r.vdd;
   assign ref_cfg.bufd = ctl_r.bufd & ~ctl_r.vdd;
   assign ref_cfg.gain = ctl_r.gain & ~ctl_r.vdd;

   // ----------------------------------------
   // Input and output code registers
   // ----------------------------------------
   logic [NUM_CH-1:0][CODE_W-1:0] in_code_r;
   logic [NUM_CH-1:0] dirty_r;

   // Only channels written since their last update move, to spare glitches
   wire load_all = load_pin_low || (ctl_r.load_mode == LOAD_CONT) || do_single;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         in_code_r <= '0;
         dac_code <= '0;
         dirty_r <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (do_clear) begin
               in_code_r[i] <= '0;
               dac_code[i] <= '0;
               dirty_r[i] <= 1'b0;
            end else begin
               if (load_all && dirty_r[i]) begin
                  dac_code[i] <= in_code_r[i];
                  dirty_r[i] <= 1'b0;
               end
               // A write in the update cycle keeps its dirty flag
               if (data_wr && wr_ch == CH_W'(i)) begin
                  in_code_r[i] <= wr_code;
                  dirty_r[i] <= 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Power-down and wake timing
   // ----------------------------------------
   logic [NUM_CH-1:0] pd_prev_r, waking_r;
   logic [EXIT_W-1:0] exit_cnt_r;

   wire [NUM_CH-1:0] leaving = pd_prev_r & ~ctl_r.pd;
   wire [EXIT_W-1:0] exit_cyc = ctrl_r[CTRL_LOWV_BIT] ? EXIT_3V_CYC : EXIT_5V_CYC;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pd_prev_r <= '0;
         waking_r <= '0;
         exit_cnt_r <= '0;
      end else begin
         pd_prev_r <= ctl_r.pd;
         if (|leaving) begin
            exit_cnt_r <= exit_cyc;
            waking_r <= (waking_r | leaving) & ~ctl_r.pd;
         end else if (exit_cnt_r != '0) begin
            exit_cnt_r <= exit_cnt_r - 9'h001;
            waking_r <= (exit_cnt_r == 9'h001) ? '0 : waking_r & ~ctl_r.pd;
         end
      end
   end

   assign chan_hiz = ctl_r.pd;
   // Leaving term covers the cycle before the wake flag is loaded
   assign chan_live = ~ctl_r.pd & ~waking_r & ~leaving;

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic aw_held_r, w_held_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [31:0] last_word_r, aborts_r;

   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire aw_have = aw_held_r || aw_fire;
   wire w_have = w_held_r || w_fire;
   wire [ADDR_W-1:0] wa = aw_held_r ? aw_addr_r : s_axi_awaddr;
   wire [31:0] wd = w_held_r ? w_data_r : s_axi_wdata;
   wire [3:0] ws = w_held_r ? w_strb_r : s_axi_wstrb;
   wire wr_go = aw_have && w_have;
   wire wa_ctrl = (wa == REG_CTRL);
   wire wa_ro = (wa == REG_STATUS) || (wa == REG_LAST) || (wa == REG_ABORTS)
      || (wa == REG_SETTINGS) || (wa[7:5] == CODE_PAGE && wa[1:0] == 2'h0);

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         ctrl_r <= CTRL_RESET;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa_ctrl || wa_ro) ? RESP_OKAY : RESP_DECERR;
            if (wa_ctrl && ws[0]) begin
               ctrl_r <= wd[1:0];
            end
         end else begin
            if (aw_fire) begin
               aw_held_r <= 1'b1;
               aw_addr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
               w_held_r <= 1'b1;
               w_data_r <= s_axi_wdata;
               w_strb_r <= s_axi_wstrb;
            end
         end
      end
   end

   // Read side
   wire [ADDR_W-1:0] ra = s_axi_araddr;
   wire ra_code = (ra[7:5] == CODE_PAGE) && (ra[1:0] == 2'h0);
   wire [31:0] status_word = {22'h0, link_st_r, chan_live};
   wire [31:0] settings_word = {16'h0, ctl_r};
   wire [31:0] rd_mux =
      (ra == REG_CTRL) ? {30'h0, ctrl_r} :
      (ra == REG_STATUS) ? status_word :
      (ra == REG_LAST) ? last_word_r :
      (ra == REG_ABORTS) ? aborts_r :
      (ra == REG_SETTINGS) ? settings_word :
      ra_code ? {20'h0, dac_code[ra[4:2]]} : 32'h0;
   wire ra_ok = (ra == REG_CTRL) || (ra == REG_STATUS) || (ra == REG_LAST)
      || (ra == REG_ABORTS) || (ra == REG_SETTINGS) || ra_code;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         last_word_r <= '0;
         aborts_r <= '0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= ra_ok ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (word_done) begin
            last_word_r <= {16'h0, shift_r};
         end
         if (frame_abort) begin
            aborts_r <= aborts_r + 32'h1;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_abort_no_change: assert property (frame_abort |=> $stable(in_code_r))
      else $error("aborted frame changed input codes");
   a_done_after_16: assert property (word_done |-> bit_cnt_r == WORD_BITS)
      else $error("word taken without sixteen bits");
   a_data_store: assert property (data_wr |=> in_code_r[$past(wr_ch)] == $past(wr_code))
      else $error("data word not stored in addressed channel");
   a_vdd_override: assert property (
      ctl_r.vdd[1] |-> !ref_cfg.bufd[1] && !ref_cfg.gain[1])
      else $error("supply reference not unbuffered unity");
   a_hiz_follow: assert property ($rose(ctl_r.pd[0]) |-> chan_hiz[0] && !chan_live[0])
      else $error("powered-down channel still driven");
   a_wake_delay: assert property (leaving[0] |-> !chan_live[0] [*8])
      else $error("channel live before wake time");
   a_transparent_load: assert property (
      (ctl_r.load_mode == LOAD_CONT) && dirty_r[3] && !do_clear
      |=> dac_code[3] == $past(in_code_r[3]))
      else $error("transparent mode did not copy code");
   a_latched_hold: assert property (
      !load_all && !do_clear |=> $stable(dac_code))
      else $error("latched outputs changed");
   a_reset_clear: assert property (do_clear |=> in_code_r == '0 && dac_code == '0)
      else $error("reset word did not clear codes");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
endmodule : octal_dac_ctl

/* File: test/serial_host.sv */
`timescale 1ns/1ps
module serial_host
   import dac_ctl_pkg::*;
(
   output logic sync_n,
   output logic sclk,
   output logic sdin
);
   localparam time HALF = 80ns;

   // Clock parks high between frames, so the first edge in a frame is a fall
   initial begin
      sync_n = 1'b1;
      sclk = 1'b1;
      sdin = 1'b0;
   end

   // ----------------------------------------
   // One frame; fewer than 16 bits gives an early end
   // ----------------------------------------
   task automatic send(input logic [WORD_W-1:0] word, input int nbits);
      logic [WORD_W-1:0] w;
      w = word;
      if (!w[TYPE_BIT]) w[CODE_W-1:0] = w[CODE_W-1:0] & CODE_MASK;
      #3;
      sync_n = 1'b0;
      for (int i = WORD_W - 1; i >= WORD_W - nbits; i--) begin
         sdin = w[i];
         #HALF sclk = 1'b0;
         #HALF sclk = 1'b1;
      end
      #HALF sync_n = 1'b1;
      // Released line must not keep showing the last bit
      sdin = ~sdin;
      #(3 * HALF);
   endtask : send

   // Clock pulses with the frame select idle
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         sdin = ~sdin;
         #HALF sclk = 1'b0;
         #HALF sclk = 1'b1;
      end
   endtask : stray
endmodule : serial_host

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import dac_ctl_pkg::*;
;
   logic ref_clk = 1'b0;
   logic resetn;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic sync_n, sclk, sdin, load_output_n;
   logic [NUM_CH-1:0][CODE_W-1:0] dac_code, exp_code;
   ref_cfg_t ref_cfg;
   logic [NUM_CH-1:0] chan_hiz, chan_live;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;

   always #10 ref_clk = ~ref_clk;

   octal_dac_ctl dut (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_n, .sclk, .sdin, .load_output_n,
      .dac_code, .ref_cfg, .chan_hiz, .chan_live);

   serial_host host (.sync_n, .sclk, .sdin);

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic codes_chk(input logic [NUM_CH-1:0][CODE_W-1:0] e);
      for (int i = 0; i < NUM_CH; i++) chk({20'h0, dac_code[i]}, {20'h0, e[i]}, "code");
   endtask : codes_chk

   // Starts one edge late so a release never meets a new request in one step
   // Handshakes are judged at the falling edge, where the ready outputs have settled
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic aw_hs, w_hs, b_hs;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge ref_clk);
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         b_hs = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge ref_clk);
         if (aw_hs) s_axi_awvalid <= 1'b0;
         if (w_hs) s_axi_wvalid <= 1'b0;
      end while (!b_hs);
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [ADDR_W-1:0] a);
      logic ar_hs, r_hs;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge ref_clk);
         ar_hs = s_axi_arvalid && s_axi_arready;
         r_hs = s_axi_rvalid;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge ref_clk);
         if (ar_hs) s_axi_arvalid <= 1'b0;
      end while (!r_hs);
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string what);
      axi_rd(a);
      chk(rd, e, what);
   endtask : rd_chk

   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // Whole run is roughly 26 frames of about 150 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("Error at %0t: run timed out", $time);
         conclude;
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      resetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      load_output_n = 1'b1;
      exp_code = '0;
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (5) @(posedge ref_clk);
      codes_chk('0);
      rd_chk(REG_SETTINGS, 32'h0000_4000, "defaults");
      chk({18'h0, ref_cfg, chan_hiz}, 32'h0, "default cfg");
      rd_chk(REG_CTRL, 32'h1, "ctrl reset");
      axi_rd(8'h18);
      chk({30'h0, resp}, {30'h0, RESP_DECERR}, "unmapped read");
      axi_wr(8'h18, 32'h0);
      chk({30'h0, resp}, {30'h0, RESP_DECERR}, "unmapped write");
      $display("test defaults done");

      host.stray(3);
      for (int i = 0; i < NUM_CH; i++) begin
         exp_code[i] = 12'(12'h111 * (i + 1));
         host.send({1'b0, 3'(i), exp_code[i]}, 16);
      end
      codes_chk('0);
      rd_chk(REG_LAST, {17'h0, 3'h7, exp_code[7]}, "last word");
      @(posedge ref_clk);
      load_output_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      load_output_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      codes_chk(exp_code);
      $display("test latched writes done");

      host.send(16'ha000, 16);
      rd_chk(REG_SETTINGS, 32'h0, "mode cont");
      exp_code[3] = 12'hfff;
      host.send({4'h3, 12'hfff}, 16);
      codes_chk(exp_code);
      host.send(16'ha001, 16);
      host.send({4'h0, 12'h000}, 16);
      codes_chk(exp_code);
      exp_code[0] = 12'h000;
      host.send(16'ha002, 16);
      codes_chk(exp_code);
      host.send(16'ha003, 16);
      rd_chk(REG_SETTINGS, 32'h0000_4000, "single/rsvd");
      $display("test load modes done");

      host.send(16'ha000, 16);
      host.send({4'h1, 12'h5a5}, 15);
      codes_chk(exp_code);
      rd_chk(REG_ABORTS, 32'h1, "aborts");
      $display("test abort done");

      host.send(16'h803c, 16);
      chk({26'h0, ref_cfg}, {26'h0, 6'b00_11_11}, "buf gain");
      host.send(16'h803e, 16);
      chk({26'h0, ref_cfg}, {26'h0, 6'b10_01_01}, "supply ref");
      $display("test reference done");

      host.send(16'hc081, 16);
      chk({24'h0, chan_hiz}, 32'h81, "pd map");
      chk({24'h0, chan_live}, 32'h7e, "live pd");
      exp_code[7] = 12'habc;
      host.send({4'h7, 12'habc}, 16);
      codes_chk(exp_code);
      host.send(16'hc000, 16);
      chk({24'h0, chan_hiz, chan_live}, 32'h7e, "waking");
      repeat (125) @(posedge ref_clk);
      chk({24'h0, chan_live}, 32'hff, "awake");
      axi_wr(REG_CTRL, 32'h3);
      rd_chk(REG_CTRL, 32'h3, "ctrl write");
      host.send(16'hc001, 16);
      host.send(16'hc000, 16);
      repeat (125) @(posedge ref_clk);
      chk({24'h0, chan_live}, 32'hfe, "slow wake");
      repeat (130) @(posedge ref_clk);
      chk({24'h0, chan_live}, 32'hff, "slow awake");
      rd_chk(REG_STATUS, 32'h0000_00ff, "status");
      rd_chk(8'h3c, {20'h0, 12'habc}, "code page");
      axi_wr(REG_CTRL, 32'h1);
      $display("test power-down done");

      host.send(16'he000, 16);
      codes_chk('0);
      rd_chk(REG_SETTINGS, 32'h0000_2f00, "data reset");
      host.send(16'hf000, 16);
      rd_chk(REG_SETTINGS, 32'h0000_4000, "full reset");
      chk({26'h0, ref_cfg}, 32'h0, "cfg reset");
      axi_wr(REG_CTRL, 32'h0);
      host.send({4'h2, 12'h321}, 16);
      rd_chk(REG_LAST, 32'h0000_f000, "link off");
      axi_wr(REG_CTRL, 32'h1);
      $display("test reset done");
      conclude;
   end
endmodule : tb_top
